//--- core/nctst_pkg.sv
// constants and state type for the node control, status and timer block
package nctst_pkg;
    // ---------------------------------------------------------------
    // register addresses
    // ---------------------------------------------------------------
    localparam logic [31:0] ADDR_NODE_NUM = 32'hfff73000;
    localparam logic [31:0] ADDR_STATUS = 32'hfff75000;
    localparam logic [31:0] ADDR_ELAPSED = 32'hfff7b000;
    localparam logic [31:0] ADDR_IT_SHORT = 32'hfff7c000;
    localparam logic [31:0] ADDR_IT_LONG = 32'hfff7c002;
    localparam logic [31:0] ADDR_UC_DIS = 32'hfff88000;
    localparam logic [31:0] ADDR_UC_INC = 32'hfff88004;
    localparam logic [31:0] ADDR_UC_ENB = 32'hfff88008;
    localparam logic [31:0] ADDR_UC_LOW = 32'hfff88010;
    localparam logic [31:0] ADDR_UC_HIGH = 32'hfff88014;
    // access sizes on size_i
    localparam logic [1:0] SZ_BYTE = 2'h0;
    localparam logic [1:0] SZ_WORD = 2'h1;
    localparam logic [1:0] SZ_LONG = 2'h2;
    // ---------------------------------------------------------------
    // status bit positions
    // ---------------------------------------------------------------
    localparam int B_PWR_LOW = 15;
    localparam int B_PWR_INT = 14;
    localparam int B_RMT_ERR = 12;
    localparam int B_REP_TO = 11;
    localparam int B_REQ_TO = 10;
    localparam int B_UNEX = 9;
    localparam int B_HCE = 8;
    localparam int B_ACK = 7;
    localparam int B_REQ = 6;
    localparam int B_VLM = 5;
    localparam int B_MISC = 3;
    localparam int B_HOST = 2;
    localparam int B_HALT = 1;
    localparam int B_STRAY = 0;
    localparam logic [15:0] STATUS_MASK = 16'hdfef;
    localparam logic [15:0] STATUS_RST = 16'h0000;
    // ---------------------------------------------------------------
    // reset values, sizes and timing
    // ---------------------------------------------------------------
    localparam logic [7:0] NODE_NUM_RST = 8'h00;
    localparam logic [31:0] ELAPSED_RST = 32'h00000000;
    localparam logic [15:0] ITIMER_MAX = 16'hffff;
    localparam int CS_WORDS = 4096;
    localparam int CLK_PERIOD_PS = 5000;
    localparam int TICK_PS = 62500000;
    localparam int TICK_CYCLES = TICK_PS / CLK_PERIOD_PS;

    typedef struct packed {
        logic [15:0] status;
        logic [7:0] node_num;
        logic [11:0] uaddr;
        logic run;
        logic [31:0] elapsed;
        logic [15:0] itimer;
        logic [13:0] tick_cnt;
        logic pf_s1;
        logic pf_s2;
        logic halting;
        logic ack;
        logic fault;
        logic irq2;
        logic [31:0] rdata;
    } nctst_state_t;
endpackage : nctst_pkg

//--- core/nctst_top.sv
// node controller status register, control store loader and timers
`timescale 1ns/1ps
`default_nettype none
module nctst_top import nctst_pkg::*; #(
    parameter int TICK_CNT = TICK_CYCLES
) (
    // clock and power-on reset
    input wire logic clk_i,
    input wire logic resetn_i,
    // host reference port
    input wire logic req_i,
    input wire logic we_i,
    input wire logic [1:0] size_i,
    input wire logic [31:0] addr_i,
    input wire logic [31:0] wdata_i,
    output logic ack_o,
    output logic [31:0] rdata_o,
    // fault termination of the host access
    output logic fault_berr_o,
    // power and halt
    input wire logic power_fail_i,
    input wire logic halt_i,
    output logic node_reset_o,
    output logic refresh_mode_o,
    // error events from the switch and sequencer
    input wire logic remote_read_err_i,
    input wire logic reply_timeout_i,
    input wire logic request_timeout_i,
    input wire logic unexpected_reply_i,
    input wire logic header_cksum_err_i,
    input wire logic ack_msg_err_i,
    input wire logic req_msg_err_i,
    input wire logic varlen_msg_err_i,
    input wire logic bad_misc_fn_i,
    input wire logic bad_host_req_i,
    input wire logic stray_uint_i,
    // interrupt requests
    output logic irq7_o,
    output logic irq2_o,
    // sequencer side
    output logic ctrl_run_o,
    output logic [11:0] ucode_addr_o,
    output logic [7:0] node_num_o,
    input wire logic [11:0] seq_addr_i,
    output logic [63:0] seq_data_o
);
    // ---------------------------------------------------------------
    // state
    // ---------------------------------------------------------------
    nctst_state_t st_ff;
    nctst_state_t nxt_st;
    logic [31:0] cs_hi [0:CS_WORDS-1];
    logic [31:0] cs_lo [0:CS_WORDS-1];
    logic [63:0] seq_data_ff;

    // decoded references
    logic ref_dis, ref_inc, ref_enb, wr_low, wr_high;
    logic rd_status, wr_node, wr_elapsed, wr_short, wr_long;
    logic tick, expire, halt_go, halt_done;
    logic [15:0] ev;
    logic [15:0] wval;

    // address-only references act on reads and writes alike
    assign ref_dis = req_i && addr_i == ADDR_UC_DIS;
    assign ref_inc = req_i && addr_i == ADDR_UC_INC;
    assign ref_enb = req_i && addr_i == ADDR_UC_ENB;
    assign wr_low = req_i && we_i && addr_i == ADDR_UC_LOW;
    assign wr_high = req_i && we_i && addr_i == ADDR_UC_HIGH;
    assign rd_status = req_i && !we_i && addr_i == ADDR_STATUS;
    assign wr_node = req_i && we_i && addr_i == ADDR_NODE_NUM;
    // partial-width access to the counter is ignored
    assign wr_elapsed = req_i && we_i && size_i == SZ_LONG && addr_i == ADDR_ELAPSED;
    assign wr_short = req_i && we_i && size_i == SZ_WORD && addr_i == ADDR_IT_SHORT;
    assign wr_long = req_i && we_i && size_i == SZ_WORD && addr_i == ADDR_IT_LONG;
    assign wval = wdata_i[15:0];

    // shared 62.5 us time base
    assign tick = st_ff.tick_cnt == 14'(TICK_CNT - 1);
    assign expire = tick && st_ff.itimer == 16'h0000;
    // a halt only counts once power has warned
    assign halt_go = halt_i && st_ff.status[B_PWR_LOW] && !st_ff.halting;
    assign halt_done = st_ff.halting && !st_ff.pf_s2;

    // ---------------------------------------------------------------
    // event vector, one bit per status flag
    // ---------------------------------------------------------------
    always_comb begin
        ev = 16'h0000;
        ev[B_PWR_INT] = st_ff.pf_s2 && !st_ff.status[B_PWR_LOW];
        ev[B_PWR_LOW] = st_ff.pf_s2;
        ev[B_RMT_ERR] = remote_read_err_i;
        ev[B_REP_TO] = reply_timeout_i;
        ev[B_REQ_TO] = request_timeout_i;
        ev[B_UNEX] = unexpected_reply_i;
        ev[B_HCE] = header_cksum_err_i;
        ev[B_ACK] = ack_msg_err_i;
        ev[B_REQ] = req_msg_err_i;
        ev[B_VLM] = varlen_msg_err_i;
        ev[B_MISC] = bad_misc_fn_i;
        ev[B_HOST] = bad_host_req_i;
        ev[B_STRAY] = stray_uint_i;
        ev = ev & STATUS_MASK;
    end

    // ---------------------------------------------------------------
    // next state
    // ---------------------------------------------------------------
    always_comb begin
        nxt_st = st_ff;
        // power pin passes two flops before anything looks at it
        nxt_st.pf_s1 = power_fail_i;
        nxt_st.pf_s2 = st_ff.pf_s1;
        // status: read clears all but power low, a same-cycle event still lands
        if (rd_status) begin
            nxt_st.status = st_ff.status & (16'h0001 << B_PWR_LOW);
        end
        nxt_st.status = nxt_st.status | ev;
        if (halt_go) begin
            // keep power low so no second level 7 fires
            nxt_st.status = (16'h0001 << B_HALT) | (16'h0001 << B_PWR_LOW);
            nxt_st.halting = 1'b1;
            nxt_st.run = 1'b0;
            nxt_st.uaddr = 12'h000;
        end else if (halt_done) begin
            nxt_st.halting = 1'b0;
            nxt_st.status[B_PWR_LOW] = 1'b0;
        end
        // switch node number
        if (wr_node) begin
            nxt_st.node_num = wdata_i[7:0];
        end
        // control store pointer and run state
        if (ref_dis) begin
            nxt_st.run = 1'b0;
            nxt_st.uaddr = 12'h000;
        end else if (ref_inc) begin
            nxt_st.uaddr = st_ff.uaddr + 12'h001;
        end else if (ref_enb && !st_ff.halting) begin
            nxt_st.run = 1'b1;
        end
        // elapsed counter, a write beats the tick
        nxt_st.tick_cnt = tick ? 14'h0000 : st_ff.tick_cnt + 14'h0001;
        if (wr_elapsed) begin
            nxt_st.elapsed = wdata_i;
        end else if (tick) begin
            nxt_st.elapsed = st_ff.elapsed + 32'h00000001;
        end
        // interval timer: host loads only move it one way
        if (wr_short) begin
            if (wval < st_ff.itimer) begin
                nxt_st.itimer = wval;
            end
        end else if (wr_long) begin
            if (wval > st_ff.itimer) begin
                nxt_st.itimer = wval;
            end
        end else if (expire) begin
            nxt_st.itimer = ITIMER_MAX;
        end else if (tick) begin
            nxt_st.itimer = st_ff.itimer - 16'h0001;
        end
        nxt_st.irq2 = expire;
        // host answer, one cycle after the request
        nxt_st.ack = req_i;
        nxt_st.fault = reply_timeout_i || request_timeout_i
            || bad_host_req_i || stray_uint_i;
        nxt_st.rdata = 32'h00000000;
        if (req_i && !we_i) begin
            case (addr_i)
                ADDR_NODE_NUM: nxt_st.rdata = {24'h000000, st_ff.node_num};
                ADDR_STATUS: nxt_st.rdata = {16'h0000, st_ff.status};
                ADDR_ELAPSED: begin
                    if (size_i == SZ_LONG) begin
                        nxt_st.rdata = st_ff.elapsed;
                    end
                end
                default: nxt_st.rdata = 32'h00000000;
            endcase
        end
    end

    // ---------------------------------------------------------------
    // state register
    // ---------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            st_ff <= '0;
            st_ff.status <= STATUS_RST;
            st_ff.node_num <= NODE_NUM_RST;
            st_ff.elapsed <= ELAPSED_RST;
            st_ff.itimer <= ITIMER_MAX;
            st_ff.run <= 1'b0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    // ---------------------------------------------------------------
    // control store, written at the current pointer
    // ---------------------------------------------------------------
    // no reset: contents are loaded by the host before enabling
    always_ff @(posedge clk_i) begin
        if (wr_high) begin
            cs_hi[st_ff.uaddr] <= wdata_i;
        end
        if (wr_low) begin
            cs_lo[st_ff.uaddr] <= wdata_i;
        end
        seq_data_ff <= {cs_hi[seq_addr_i], cs_lo[seq_addr_i]};
    end

    // ---------------------------------------------------------------
    // outputs
    // ---------------------------------------------------------------
    assign ack_o = st_ff.ack;
    assign rdata_o = st_ff.rdata;
    assign fault_berr_o = st_ff.fault;
    assign node_reset_o = st_ff.halting;
    assign refresh_mode_o = st_ff.halting;
    // level 7 stays until the host reads status or a halt starts
    assign irq7_o = st_ff.status[B_PWR_INT] || st_ff.status[B_RMT_ERR];
    assign irq2_o = st_ff.irq2;
    assign ctrl_run_o = st_ff.run;
    assign ucode_addr_o = st_ff.uaddr;
    assign node_num_o = st_ff.node_num;
    assign seq_data_o = seq_data_ff;

    // ---------------------------------------------------------------
    // checks
    // ---------------------------------------------------------------
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!resetn_i);

    chk_pwr_irq_raise: assert property (
        $rose(st_ff.pf_s2) && !st_ff.status[B_PWR_LOW] && !halt_go
        |=> st_ff.status[B_PWR_INT] && irq7_o)
        else $error("power failure did not raise level 7");
    chk_pwr_low_sticks: assert property (
        st_ff.status[B_PWR_LOW] && !halt_done |=> st_ff.status[B_PWR_LOW]
        && !(ev[B_PWR_INT]))
        else $error("power low flag lost or repeat interrupt");
    chk_read_clears: assert property (
        rd_status && ev == 16'h0000 && !halt_go |=> st_ff.status[14:0] == 15'h0000)
        else $error("status read did not clear flags");
    chk_halt_entry: assert property (
        halt_go |=> st_ff.status == 16'h8002 && node_reset_o && refresh_mode_o)
        else $error("halt did not start node reset");
    chk_halt_holds: assert property (
        st_ff.halting && st_ff.pf_s2 |=> st_ff.halting)
        else $error("node reset ended while power low");
    chk_remote_err: assert property (
        remote_read_err_i && !halt_go |=> st_ff.status[B_RMT_ERR] && irq7_o)
        else $error("remote read error not flagged");
    chk_fault_berr: assert property (
        reply_timeout_i || request_timeout_i |=> fault_berr_o)
        else $error("timeout gave no bus error");
    chk_switch_err: assert property (
        header_cksum_err_i && !halt_go && !ev[B_RMT_ERR] && !ev[B_PWR_INT]
        |=> st_ff.status[B_HCE] && !$rose(irq7_o))
        else $error("checksum error not flagged");
    chk_disable_zero: assert property (
        ref_dis |=> !ctrl_run_o && ucode_addr_o == 12'h000)
        else $error("disable did not stop and zero");
    chk_incr_step: assert property (
        ref_inc && !halt_go |=> ucode_addr_o == $past(ucode_addr_o) + 12'h001)
        else $error("increment did not advance pointer");
    chk_enable_run: assert property (
        ref_enb && !st_ff.halting && !halt_go |=> ctrl_run_o)
        else $error("enable did not start controller");
    chk_shorten_only: assert property (
        wr_short |=> st_ff.itimer <= $past(st_ff.itimer))
        else $error("shorten write lengthened timer");
    chk_lengthen_only: assert property (
        wr_long |=> st_ff.itimer >= $past(st_ff.itimer))
        else $error("lengthen write shortened timer");
    chk_expire_reload: assert property (
        expire && !wr_short && !wr_long |=> irq2_o && st_ff.itimer == 16'hffff)
        else $error("expiry did not reload and interrupt");
    chk_elapsed_step: assert property (
        tick && !wr_elapsed |=> st_ff.elapsed == $past(st_ff.elapsed) + 32'h00000001)
        else $error("elapsed counter missed a tick");

    // ---------------------------------------------------------------
    // reset, node number, flag, store, timer and halt checks
    // ---------------------------------------------------------------
    chk_reset_idle: assert property (
        $rose(resetn_i) |-> !ctrl_run_o && !node_reset_o && !irq7_o)
        else $error("controller not idle after reset");
    chk_node_write: assert property (
        wr_node |=> node_num_o == $past(wdata_i[7:0]))
        else $error("node number not written");
    chk_reply_timeout: assert property (
        reply_timeout_i && !halt_go |=> st_ff.status[B_REP_TO])
        else $error("reply timeout not flagged");
    chk_req_timeout: assert property (
        request_timeout_i && !halt_go |=> st_ff.status[B_REQ_TO])
        else $error("request timeout not flagged");
    chk_unex_flag: assert property (
        unexpected_reply_i && !halt_go |=> st_ff.status[B_UNEX])
        else $error("unexpected reply not flagged");
    chk_vlm_flag: assert property (
        varlen_msg_err_i && !halt_go |=> st_ff.status[B_VLM])
        else $error("varlen error not flagged");
    chk_misc_flag: assert property (
        bad_misc_fn_i && !halt_go |=> st_ff.status[B_MISC])
        else $error("misc function error not flagged");
    chk_host_berr: assert property (
        bad_host_req_i && !halt_go |=> st_ff.status[B_HOST] && fault_berr_o)
        else $error("bad host request not flagged");
    chk_stray_flag: assert property (
        stray_uint_i && !halt_go |=> st_ff.status[B_STRAY] && fault_berr_o)
        else $error("stray microinterrupt not flagged");
    chk_unused_zero: assert property (
        st_ff.status[13] == 1'b0 && st_ff.status[4] == 1'b0)
        else $error("unassigned status bit set");
    chk_elapsed_write: assert property (
        wr_elapsed |=> st_ff.elapsed == $past(wdata_i))
        else $error("elapsed counter not written");
    chk_narrow_ignored: assert property (
        req_i && we_i && size_i != SZ_LONG && addr_i == ADDR_ELAPSED && !tick
        |=> $stable(st_ff.elapsed))
        else $error("narrow write changed elapsed counter");
    chk_store_high: assert property (
        wr_high |=> cs_hi[$past(st_ff.uaddr)] == $past(wdata_i))
        else $error("high half not stored");
    chk_store_low: assert property (
        wr_low |=> cs_lo[$past(st_ff.uaddr)] == $past(wdata_i))
        else $error("low half not stored");
    chk_halt_release: assert property (
        halt_done |=> !node_reset_o && !st_ff.status[B_PWR_LOW])
        else $error("halt reset did not finish");
    chk_halt_stops: assert property (
        st_ff.halting |-> !ctrl_run_o)
        else $error("controller running during halt reset");
    chk_tick_count: assert property (
        !tick |=> st_ff.tick_cnt == $past(st_ff.tick_cnt) + 14'h0001)
        else $error("time base skipped a count");

    cov_halt_cycle: cover property (halt_go ##[1:300] halt_done);
    cov_load_word: cover property (wr_high ##2 wr_low ##2 ref_inc);
    cov_expire: cover property (expire);
    cov_read_race: cover property (rd_status && ev != 16'h0000);
    cov_power_warn: cover property ($rose(irq7_o));
endmodule : nctst_top
`default_nettype wire

//--- verif/nctst_host_model.sv
// host processor model making memory-mapped references to the block
`timescale 1ns/1ps
`default_nettype none
module nctst_host_model import nctst_pkg::*; (
    // clock
    input wire logic clk_i,
    // reference port toward the block
    output logic req_o,
    output logic we_o,
    output logic [1:0] size_o,
    output logic [31:0] addr_o,
    output logic [31:0] wdata_o,
    input wire logic ack_i,
    input wire logic [31:0] rdata_i
);
    initial begin
        req_o = 1'b0;
        we_o = 1'b0;
        size_o = SZ_LONG;
        addr_o = 32'h00000000;
        wdata_o = 32'h00000000;
    end
    // ---------------------------------------------------------------
    // one reference: one-cycle request, bounded wait for the answer
    // ---------------------------------------------------------------
    task automatic access(input logic w, input logic [1:0] sz, input logic [31:0] a,
                          input logic [31:0] d, output logic [31:0] rd, output bit ok);
        ok = 1'b0;
        rd = 32'h00000000;
        @(negedge clk_i);
        req_o = 1'b1;
        we_o = w;
        size_o = sz;
        addr_o = a;
        wdata_o = d;
        @(negedge clk_i);
        req_o = 1'b0;
        for (int n = 0; n < 4 && !ok; n++) begin
            if (ack_i === 1'b1) begin
                ok = 1'b1;
                rd = rdata_i;
            end else begin
                @(negedge clk_i);
            end
        end
        // released lines must not show a stale value
        addr_o = ~a;
        wdata_o = ~d;
    endtask : access
    // controller kept stopped while words go in, restarted at zero last
    task automatic load(input logic [63:0] w[], output bit ok);
        logic [31:0] rd;
        bit k;
        ok = 1'b1;
        repeat (2) begin
            access(1'b1, SZ_LONG, ADDR_UC_DIS, 32'h0, rd, k);
            ok &= k;
        end
        foreach (w[i]) begin
            access(1'b1, SZ_LONG, ADDR_UC_HIGH, w[i][63:32], rd, k);
            ok &= k;
            access(1'b1, SZ_LONG, ADDR_UC_LOW, w[i][31:0], rd, k);
            ok &= k;
            access(1'b1, SZ_LONG, ADDR_UC_INC, 32'h0, rd, k);
            ok &= k;
        end
        access(1'b1, SZ_LONG, ADDR_UC_DIS, 32'h0, rd, k);
        ok &= k;
        access(1'b1, SZ_LONG, ADDR_UC_ENB, 32'h0, rd, k);
        ok &= k;
    endtask : load
endmodule : nctst_host_model
`default_nettype wire

//--- verif/nctst_top_test.sv
// self-checking testbench for the node status, control store and timers
`timescale 1ns/1ps
`default_nettype none
module nctst_top_test import nctst_pkg::*;;
    localparam int TK = 8;
    logic clk_i = 1'b0;
    logic resetn_i = 1'b0;
    logic power_fail = 1'b0;
    logic halt = 1'b0;
    logic [10:0] ev = 11'h000;
    logic [11:0] seq_addr = 12'h000;
    logic req, we, ack, berr, node_reset, refresh, irq7, irq2, run;
    logic [1:0] size;
    logic [31:0] addr, wdata, rdata, rd, d;
    logic [11:0] uaddr;
    logic [7:0] node_num;
    logic [63:0] seq_data;
    logic saw_berr = 1'b0;
    logic clr_berr = 1'b0;
    int miscompares = 0;
    int samples_checked = 0;
    typedef struct packed {
        logic w; logic [1:0] sz; logic [31:0] a; logic [31:0] d; logic [31:0] e;
    } nctst_row_t;
    nctst_row_t rows[7] = '{
        '{1'b1, SZ_BYTE, ADDR_NODE_NUM, 32'h000000a5, 32'h0},
        '{1'b0, SZ_BYTE, ADDR_NODE_NUM, 32'h0, 32'h000000a5},
        '{1'b0, SZ_WORD, ADDR_STATUS, 32'h0, 32'h0},
        '{1'b0, SZ_LONG, 32'hfff74000, 32'h0, 32'h0},
        '{1'b0, SZ_WORD, ADDR_IT_SHORT, 32'h0, 32'h0},
        '{1'b1, SZ_BYTE, ADDR_NODE_NUM, 32'h0000003c, 32'h0},
        '{1'b0, SZ_BYTE, ADDR_NODE_NUM, 32'h0, 32'h0000003c}};
    int pos[11] = '{B_RMT_ERR, B_REP_TO, B_REQ_TO, B_UNEX, B_HCE, B_ACK, B_REQ,
                    B_VLM, B_MISC, B_HOST, B_STRAY};
    logic [63:0] words[] = '{64'h0123456789abcdef, 64'hfedcba9876543210,
                             64'h00ff00ff5a5aa5a5};
    bit ok;

    nctst_top #(.TICK_CNT(TK)) dut (.clk_i(clk_i), .resetn_i(resetn_i), .req_i(req),
        .we_i(we), .size_i(size), .addr_i(addr), .wdata_i(wdata), .ack_o(ack),
        .rdata_o(rdata), .fault_berr_o(berr), .power_fail_i(power_fail), .halt_i(halt),
        .node_reset_o(node_reset), .refresh_mode_o(refresh), .remote_read_err_i(ev[0]),
        .reply_timeout_i(ev[1]), .request_timeout_i(ev[2]), .unexpected_reply_i(ev[3]),
        .header_cksum_err_i(ev[4]), .ack_msg_err_i(ev[5]), .req_msg_err_i(ev[6]),
        .varlen_msg_err_i(ev[7]), .bad_misc_fn_i(ev[8]), .bad_host_req_i(ev[9]),
        .stray_uint_i(ev[10]), .irq7_o(irq7), .irq2_o(irq2), .ctrl_run_o(run),
        .ucode_addr_o(uaddr), .node_num_o(node_num), .seq_addr_i(seq_addr),
        .seq_data_o(seq_data));
    nctst_host_model u_host (.clk_i(clk_i), .req_o(req), .we_o(we), .size_o(size),
        .addr_o(addr), .wdata_o(wdata), .ack_i(ack), .rdata_i(rdata));

    // 200 MHz clock
    initial begin
        forever #2.5 clk_i = ~clk_i;
    end
    // bus errors are short pulses, so latch them; one writer keeps it race-free
    always @(posedge clk_i) begin
        saw_berr <= !clr_berr && (saw_berr || berr === 1'b1);
    end
    // ---------------------------------------------------------------
    // helpers
    // ---------------------------------------------------------------
    task automatic summarize();
        $display("checks made %0d, mismatches %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : summarize
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            miscompares++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic acc(input logic w, input logic [1:0] sz, input logic [31:0] a,
                       input logic [31:0] dd);
        bit k;
        u_host.access(w, sz, a, dd, rd, k);
        if (!k) begin
            miscompares++;
            summarize();
        end
    endtask : acc
    task automatic cyc(input int n);
        repeat (n) @(negedge clk_i);
    endtask : cyc
    task automatic reset_dut();
        resetn_i = 1'b0;
        cyc(10);
        resetn_i = 1'b1;
    endtask : reset_dut
    // irq2 must arrive between lo and hi cycles from now
    task automatic wait_irq2(input int lo, input int hi);
        int n;
        for (n = 0; n <= hi; n++) begin
            @(negedge clk_i);
            if (irq2 === 1'b1) break;
        end
        chk({31'h0, n >= lo && n <= hi}, 32'h1);
        if (n > hi) summarize();
    endtask : wait_irq2
    // ---------------------------------------------------------------
    // main sequence
    // ---------------------------------------------------------------
    initial begin
        reset_dut();
        chk({29'h0, run, irq7, node_reset}, 32'h0);
        foreach (rows[i]) begin
            acc(rows[i].w, rows[i].sz, rows[i].a, rows[i].d);
            chk(rd, rows[i].e);
        end
        chk({24'h0, node_num}, 32'h3c);
        $display("register table rows done");
        // each event sets only its own flag; reading clears it
        for (int i = 0; i < 11; i++) begin
            clr_berr = 1'b1;
            ev[i] = 1'b1;
            @(negedge clk_i);
            clr_berr = 1'b0;
            ev[i] = 1'b0;
            cyc(2);
            chk({31'h0, irq7}, {31'h0, i == 0});
            acc(1'b0, SZ_WORD, ADDR_STATUS, 32'h0);
            chk(rd, 32'h1 << pos[i]);
            chk({31'h0, saw_berr}, {31'h0, i inside {1, 2, 9, 10}});
            acc(1'b0, SZ_WORD, ADDR_STATUS, 32'h0);
            chk(rd, 32'h0);
            chk({31'h0, irq7}, 32'h0);
        end
        $display("status events done");
        // control store load, then pointer handling
        u_host.load(words, ok);
        chk({30'h0, run, ok}, 32'h3);
        foreach (words[i]) begin
            seq_addr = 12'(i);
            cyc(2);
            chk(seq_data[63:32], words[i][63:32]);
            chk(seq_data[31:0], words[i][31:0]);
        end
        acc(1'b1, SZ_LONG, ADDR_UC_DIS, 32'h0);
        acc(1'b1, SZ_LONG, ADDR_UC_INC, 32'h0);
        acc(1'b0, SZ_LONG, ADDR_UC_INC, 32'h0);
        chk({19'h0, run, uaddr}, 32'h2);
        acc(1'b1, SZ_LONG, ADDR_UC_ENB, 32'h0);
        chk({19'h0, run, uaddr}, 32'h1002);
        acc(1'b1, SZ_LONG, ADDR_UC_DIS, 32'hffffffff);
        chk({19'h0, run, uaddr}, 32'h0);
        $display("control store done");
        // elapsed counter advances per tick, wraps, ignores narrow access
        acc(1'b1, SZ_LONG, ADDR_ELAPSED, 32'hfffffffe);
        cyc(3 * TK);
        acc(1'b0, SZ_LONG, ADDR_ELAPSED, 32'h0);
        d = rd - 32'hfffffffe;
        chk({31'h0, d >= 2 && d <= 4}, 32'h1);
        acc(1'b1, SZ_WORD, ADDR_ELAPSED, 32'h00001234);
        acc(1'b0, SZ_LONG, ADDR_ELAPSED, 32'h0);
        chk({31'h0, rd < 16}, 32'h1);
        acc(1'b0, SZ_WORD, ADDR_ELAPSED, 32'h0);
        chk(rd, 32'h0);
        $display("elapsed counter done");
        // interval timer: shorten accepts smaller only, lengthen larger only
        acc(1'b1, SZ_WORD, ADDR_IT_SHORT, 32'h5);
        acc(1'b1, SZ_WORD, ADDR_IT_SHORT, 32'ha);
        acc(1'b1, SZ_WORD, ADDR_IT_LONG, 32'h2);
        wait_irq2(30, 56);
        for (int n = 0; n < 200; n++) begin
            @(negedge clk_i);
            chk({31'h0, irq2}, 32'h0);
        end
        acc(1'b1, SZ_WORD, ADDR_IT_SHORT, 32'h3);
        acc(1'b1, SZ_WORD, ADDR_IT_LONG, 32'hc);
        wait_irq2(88, 112);
        $display("interval timer done");
        // power warning, halt, recovery, then a fresh power-on reset
        power_fail = 1'b1;
        cyc(5);
        chk({31'h0, irq7}, 32'h1);
        acc(1'b0, SZ_WORD, ADDR_STATUS, 32'h0);
        chk(rd, 32'hc000);
        acc(1'b0, SZ_WORD, ADDR_STATUS, 32'h0);
        chk(rd, 32'h8000);
        chk({31'h0, irq7}, 32'h0);
        ev[3] = 1'b1;
        halt = 1'b1;
        @(negedge clk_i);
        ev[3] = 1'b0;
        halt = 1'b0;
        cyc(20);
        chk({29'h0, node_reset, refresh, run}, 32'h6);
        acc(1'b0, SZ_WORD, ADDR_STATUS, 32'h0);
        chk(rd, 32'h8002);
        power_fail = 1'b0;
        cyc(8);
        chk({30'h0, node_reset, refresh}, 32'h0);
        // second warning and halt, cut short by a power-on reset
        power_fail = 1'b1;
        cyc(5);
        halt = 1'b1;
        @(negedge clk_i);
        halt = 1'b0;
        reset_dut();
        power_fail = 1'b0;
        chk({31'h0, node_reset}, 32'h0);
        acc(1'b0, SZ_WORD, ADDR_STATUS, 32'h0);
        chk(rd, 32'h0);
        $display("power and halt done");
        summarize();
    end
endmodule : nctst_top_test
`default_nettype wire
